// ### inc/tof_cfg_pkg.sv
// Purpose: constants for the ambient / event-routing configuration bank
// Assumes: 24-bit registers on a simple word port, one system clock
// Notes: field positions and reset values are defined here; the bench and some RTL checks repeat them as literals
package tof_cfg_pkg;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ROUTE = 8'h0B;
  localparam logic [7:0] OFS_COEF = 8'h0C;
  localparam logic [7:0] OFS_SAT = 8'h0D;
  localparam logic [7:0] OFS_FREQ = 8'h0F;
  localparam logic [23:0] RST_ROUTE = 24'h0FC009;
  localparam logic [23:0] RST_COEF = 24'h000000;
  localparam logic [23:0] RST_SAT = 24'h006000;
  localparam logic [23:0] RST_FREQ = 24'h144C4B;
  // writable bit masks; reserved bits stay zero
  localparam logic [23:0] MSK_ROUTE = 24'hFFFCFF;
  localparam logic [23:0] MSK_COEF = 24'hFFFFFF;
  localparam logic [23:0] MSK_SAT = 24'h81FF80;
  localparam logic [23:0] MSK_FREQ = 24'hFF7FFF;
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 4;
  localparam int SEL2_LSB = 10;
  localparam int CAL_LSB = 14;
  localparam int IQ_LSB = 0;
  localparam int QQ_LSB = 8;
  localparam int PWL_LSB = 16;
  localparam int SAT_LSB = 7;
  localparam int WIDE_BIT = 23;
  localparam int START_BIT = 16;
  localparam int DIV_LSB = 17;
  localparam int AUTO_BIT = 21;
  localparam int FLOOP_BIT = 22;
  localparam int FCORR_BIT = 23;
  localparam int REFLIM_LSB = 0;
  localparam int OVL_BIT = 22;
  localparam int AMB_LSB = 2;
  localparam logic [3:0] EV_FRAME = 4'h0;
  localparam logic [3:0] EV_SUB = 4'h1;
  localparam logic [3:0] EV_SEQ = 4'h4;
  localparam logic [3:0] EV_CMP = 4'h8;
  localparam logic [3:0] EV_RDY = 4'h9;
  localparam logic [3:0] EV_TALLY = 4'hA;
  localparam logic [3:0] TEMP_NARROW = 4'h8;
  localparam logic [3:0] TEMP_WIDE = 4'hC;
endpackage

// ### rtl/event_route_mux.sv
// Purpose: one event selector
// Assumes: events are same-clock logic
// Notes: registered event output; the valid flag is combinational
`timescale 1ns/100ps
`default_nettype none
module event_route_mux (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_sel,
  input wire logic [5:0] i_events,
  output logic o_event,
  output logic o_valid
);
  logic event_d;
  logic event_q;
  logic valid_w;
  assign valid_w = (i_sel == tof_cfg_pkg::EV_FRAME) || (i_sel == tof_cfg_pkg::EV_SUB) ||
                   (i_sel == tof_cfg_pkg::EV_SEQ) || (i_sel == tof_cfg_pkg::EV_CMP) ||
                   (i_sel == tof_cfg_pkg::EV_RDY) || (i_sel == tof_cfg_pkg::EV_TALLY);
  always_comb begin
    case (i_sel)
      tof_cfg_pkg::EV_FRAME: event_d = i_events[0];
      tof_cfg_pkg::EV_SUB: event_d = i_events[1];
      tof_cfg_pkg::EV_SEQ: event_d = i_events[2];
      tof_cfg_pkg::EV_CMP: event_d = i_events[3];
      tof_cfg_pkg::EV_RDY: event_d = i_events[4];
      tof_cfg_pkg::EV_TALLY: event_d = i_events[5];
      default: event_d = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_d;
    end
  end
  assign o_event = event_q;
  assign o_valid = valid_w;
  chk_invalid_low: assert property (@(posedge i_clk) disable iff (i_srst)
    !valid_w |=> !o_event) else $error("invalid code routed an event");
  chk_rdy_follow: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_sel == tof_cfg_pkg::EV_RDY) |=> (o_event == $past(i_events[4])))
    else $error("result-available not routed");
endmodule
`default_nettype wire

// ### rtl/ambient_overload.sv
// Purpose: ambient overload compare
// Assumes: ambient result and limit are same-clock values
// Notes: signed difference so a result below the point never overloads
`timescale 1ns/100ps
`default_nettype none
module ambient_overload #(
  parameter int AMB_W = 10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [AMB_W-1:0] i_result,
  input wire logic [AMB_W-1:0] i_point,
  input wire logic [AMB_W-1:0] i_limit,
  output logic o_overload
);
  if (AMB_W < 1 || AMB_W > 16) begin : g_bad_width
    $error("AMB_W out of range");
  end
  logic signed [AMB_W+1:0] diff_w;
  logic over_d;
  logic over_q;
  assign diff_w = $signed({2'b00, i_result}) - $signed({2'b00, i_point});
  assign over_d = diff_w > $signed({2'b00, i_limit});
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      over_q <= 1'b0;
    end else begin
      over_q <= over_d;
    end
  end
  assign o_overload = over_q;
  chk_ovl_compare: assert property (@(posedge i_clk) disable iff (i_srst)
    ({2'b00, i_result} > {2'b00, i_point} + {2'b00, i_limit}) |=> o_overload)
    else $error("overload not raised");
  chk_ovl_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_result <= i_point) |=> !o_overload) else $error("overload raised below point");
endmodule
`default_nettype wire

// ### rtl/tof_config_mux_ambient_regs.sv
// Purpose: configuration bank for event routing, ambient overload and coefficients
// Assumes: the control-bus front end gives a word port with a one-cycle write strobe
// Notes: events and ambient result come from same-clock logic; bus reads are registered
`timescale 1ns/100ps
`default_nettype none
module tof_config_mux_ambient_regs (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [23:0] i_wdata,
  output logic [23:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_frame_sync_pulse,
  input wire logic i_subframe_sync_pulse,
  input wire logic i_seq_interrupt,
  input wire logic i_threshold_compare,
  input wire logic i_result_available,
  input wire logic i_frame_tally_lsb,
  input wire logic [9:0] i_ambient_conversion_result,
  input wire logic i_general_pin_2_in,
  input wire logic i_general_pin_3_in,
  input wire logic i_pin1_from_sel1,
  input wire logic i_pin2_from_sel1,
  input wire logic i_pin3_route_en,
  input wire logic i_sec_data_out,
  input wire logic i_sec_data_oe,
  output logic o_general_pin_1,
  output logic o_general_pin_1_oe,
  output logic o_general_pin_2,
  output logic o_general_pin_2_oe,
  output logic o_general_pin_3,
  output logic o_general_pin_3_oe,
  output logic o_general_pin_2_sync,
  output logic o_sec_data_in,
  output logic o_ambient_overload_indicator,
  output logic [23:0] o_frame_result_bits,
  output logic [11:0] o_ambient_result_bits,
  output logic [7:0] o_ambient_phase_segment_coef,
  output logic [7:0] o_ambient_quad_leak_coef,
  output logic [7:0] o_ambient_inphase_leak_coef,
  output logic [3:0] o_temp_read_bits,
  output logic o_freq_cal_start,
  output logic o_phase_freq_fix_enable,
  output logic o_freq_cal_block_enable,
  output logic o_measured_freq_use,
  output logic [3:0] o_cal_clock_divider,
  output logic [14:0] o_ref_count_limit
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [23:0] route_q;
  logic [23:0] coef_q;
  logic [23:0] sat_q;
  logic [23:0] freq_q;
  logic [23:0] rdata_q;
  logic rvalid_q;
  logic start_q;
  logic wr_route;
  logic wr_coef;
  logic wr_sat;
  logic wr_freq;
  logic hit_w;
  logic [23:0] rd_mux;
  assign wr_route = i_wr && (i_addr == tof_cfg_pkg::OFS_ROUTE);
  assign wr_coef = i_wr && (i_addr == tof_cfg_pkg::OFS_COEF);
  assign wr_sat = i_wr && (i_addr == tof_cfg_pkg::OFS_SAT);
  assign wr_freq = i_wr && (i_addr == tof_cfg_pkg::OFS_FREQ);
  assign hit_w = (i_addr == tof_cfg_pkg::OFS_ROUTE) || (i_addr == tof_cfg_pkg::OFS_COEF) ||
                 (i_addr == tof_cfg_pkg::OFS_SAT) || (i_addr == tof_cfg_pkg::OFS_FREQ);
  // each word keeps its value until its own write; reserved bits are masked on the way in
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      route_q <= tof_cfg_pkg::RST_ROUTE;
    end else if (wr_route) begin
      route_q <= i_wdata & tof_cfg_pkg::MSK_ROUTE;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      coef_q <= tof_cfg_pkg::RST_COEF;
    end else if (wr_coef) begin
      coef_q <= i_wdata & tof_cfg_pkg::MSK_COEF;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sat_q <= tof_cfg_pkg::RST_SAT;
    end else if (wr_sat) begin
      sat_q <= i_wdata & tof_cfg_pkg::MSK_SAT;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      freq_q <= tof_cfg_pkg::RST_FREQ;
    end else if (wr_freq) begin
      freq_q <= i_wdata & tof_cfg_pkg::MSK_FREQ;
    end
  end
  // start is a one-cycle pulse per write of a 1; the stored bit reads back as written
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_freq && i_wdata[tof_cfg_pkg::START_BIT];
    end
  end
  // ----------------------------------------------------------------
  // read port, unmapped reads return zero
  // ----------------------------------------------------------------
  assign rd_mux = (i_addr == tof_cfg_pkg::OFS_ROUTE) ? route_q :
                  (i_addr == tof_cfg_pkg::OFS_COEF) ? coef_q :
                  (i_addr == tof_cfg_pkg::OFS_SAT) ? sat_q :
                  (i_addr == tof_cfg_pkg::OFS_FREQ) ? freq_q : 24'h000000;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 24'h000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 24'h000000;
      rvalid_q <= i_rd;
    end
  end
  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  // ----------------------------------------------------------------
  // event routing
  // ----------------------------------------------------------------
  logic [5:0] events_w;
  logic [2:0] routed_w;
  logic [3:0] sel_w [3];
  assign events_w = {i_frame_tally_lsb, i_result_available, i_threshold_compare,
                     i_seq_interrupt, i_subframe_sync_pulse, i_frame_sync_pulse};
  assign sel_w[0] = route_q[tof_cfg_pkg::SEL0_LSB +: 4];
  assign sel_w[1] = route_q[tof_cfg_pkg::SEL1_LSB +: 4];
  assign sel_w[2] = route_q[tof_cfg_pkg::SEL2_LSB +: 4];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_route
      event_route_mux u_mux (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_sel(sel_w[gi]),
        .i_events(events_w),
        .o_event(routed_w[gi]),
        .o_valid()
      );
    end
  endgenerate
  logic routed_event_0;
  logic routed_event_1;
  logic routed_event_2;
  assign routed_event_0 = routed_w[0];
  assign routed_event_1 = routed_w[1];
  assign routed_event_2 = routed_w[2];
  logic pin1_q;
  logic pin2_q;
  logic pin3_q;
  logic pin3_oe_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
    end else begin
      pin1_q <= i_pin1_from_sel1 ? routed_event_1 : routed_event_0;
      pin2_q <= i_pin2_from_sel1 ? routed_event_1 : routed_event_0;
    end
  end
  // pin 3 lets go of the line when neither the router nor the secondary bus owns it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin3_q <= 1'b0;
      pin3_oe_q <= 1'b0;
    end else begin
      pin3_q <= i_pin3_route_en ? routed_event_2 : i_sec_data_out;
      pin3_oe_q <= i_pin3_route_en | i_sec_data_oe;
    end
  end
  assign o_general_pin_1 = pin1_q;
  assign o_general_pin_1_oe = 1'b1;
  assign o_general_pin_2 = pin2_q;
  assign o_general_pin_2_oe = 1'b1;
  assign o_general_pin_3 = pin3_q;
  assign o_general_pin_3_oe = pin3_oe_q;
  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] p2_sync_q;
  logic [1:0] p3_sync_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      p2_sync_q <= 2'b00;
      p3_sync_q <= 2'b00;
    end else begin
      p2_sync_q <= {p2_sync_q[0], i_general_pin_2_in};
      p3_sync_q <= {p3_sync_q[0], i_general_pin_3_in};
    end
  end
  assign o_general_pin_2_sync = p2_sync_q[1];
  assign o_sec_data_in = p3_sync_q[1];
  // ----------------------------------------------------------------
  // ambient overload
  // ----------------------------------------------------------------
  logic [9:0] ambient_calibration_point;
  logic [9:0] ambient_saturation_limit;
  logic ambient_overload_indicator;
  assign ambient_calibration_point = route_q[tof_cfg_pkg::CAL_LSB +: 10];
  assign ambient_saturation_limit = sat_q[tof_cfg_pkg::SAT_LSB +: 10];
  ambient_overload #(
    .AMB_W(10)
  ) u_ovl (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_result(i_ambient_conversion_result),
    .i_point(ambient_calibration_point),
    .i_limit(ambient_saturation_limit),
    .o_overload(ambient_overload_indicator)
  );
  assign o_ambient_overload_indicator = ambient_overload_indicator;
  // status word placement for the result registers
  assign o_frame_result_bits = 24'(ambient_overload_indicator) << tof_cfg_pkg::OVL_BIT;
  assign o_ambient_result_bits = 12'(i_ambient_conversion_result) << tof_cfg_pkg::AMB_LSB;
  // ----------------------------------------------------------------
  // coefficients and control fields
  // ----------------------------------------------------------------
  assign o_ambient_phase_segment_coef = coef_q[tof_cfg_pkg::PWL_LSB +: 8];
  assign o_ambient_quad_leak_coef = coef_q[tof_cfg_pkg::QQ_LSB +: 8];
  assign o_ambient_inphase_leak_coef = coef_q[tof_cfg_pkg::IQ_LSB +: 8];
  assign o_temp_read_bits = sat_q[tof_cfg_pkg::WIDE_BIT] ? tof_cfg_pkg::TEMP_WIDE :
                            tof_cfg_pkg::TEMP_NARROW;
  assign o_freq_cal_start = start_q;
  assign o_phase_freq_fix_enable = freq_q[tof_cfg_pkg::FCORR_BIT];
  assign o_freq_cal_block_enable = freq_q[tof_cfg_pkg::FLOOP_BIT];
  assign o_measured_freq_use = freq_q[tof_cfg_pkg::AUTO_BIT];
  assign o_cal_clock_divider = freq_q[tof_cfg_pkg::DIV_LSB +: 4];
  assign o_ref_count_limit = freq_q[tof_cfg_pkg::REFLIM_LSB +: 15];
  // ----------------------------------------------------------------
  // register checks
  // ----------------------------------------------------------------
  chk_reserved_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    ((route_q & ~tof_cfg_pkg::MSK_ROUTE) == 24'h0) && ((sat_q & ~tof_cfg_pkg::MSK_SAT) == 24'h0))
    else $error("reserved bits not zero");
  chk_freq_reserved: assert property (@(posedge i_clk) disable iff (i_srst)
    (freq_q & ~tof_cfg_pkg::MSK_FREQ) == 24'h0)
    else $error("frequency reserved bit set");
  chk_sel0_reset: assert property (@(posedge i_clk)
    i_srst |=> (route_q[tof_cfg_pkg::SEL0_LSB +: 4] == tof_cfg_pkg::EV_RDY))
    else $error("selector 0 reset wrong");
  chk_route_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    !wr_route |=> $stable(route_q))
    else $error("routing word changed without a write");
  chk_calib_write: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_route |=> (ambient_calibration_point == $past(i_wdata[23:14])))
    else $error("calibration point not stored");
  chk_sat_write: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_sat |=> (ambient_saturation_limit == $past(i_wdata[16:7])))
    else $error("saturation limit not stored");
  chk_temp_width: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_sat |=> (o_temp_read_bits == ($past(i_wdata[23]) ? 4'hC : 4'h8)))
    else $error("temperature width wrong");
  chk_coef_write: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_coef |=> (o_ambient_quad_leak_coef == $past(i_wdata[15:8])) &&
    (o_ambient_phase_segment_coef == $past(i_wdata[23:16])) &&
    (o_ambient_inphase_leak_coef == $past(i_wdata[7:0])))
    else $error("coefficient not stored");
  chk_coef_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    !wr_coef |=> $stable(coef_q))
    else $error("coefficients changed without a write");
  chk_fix_enable: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_freq |=> (o_phase_freq_fix_enable == $past(i_wdata[23])))
    else $error("fix enable not stored");
  chk_start_set: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_freq && i_wdata[tof_cfg_pkg::START_BIT]) |=> o_freq_cal_start)
    else $error("start pulse missing");
  chk_start_idle: assert property (@(posedge i_clk) disable iff (i_srst)
    !(wr_freq && i_wdata[tof_cfg_pkg::START_BIT]) |=> !o_freq_cal_start)
    else $error("start pulse without a start write");
  // ----------------------------------------------------------------
  // bus and pin checks
  // ----------------------------------------------------------------
  chk_read_answer: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rd |=> o_rvalid)
    else $error("read not answered");
  chk_read_idle: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_rd |=> (!o_rvalid && (o_rdata == 24'h000000)))
    else $error("read data outside a read");
  chk_read_unmapped: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && !hit_w) |=> (o_rdata == 24'h000000))
    else $error("unmapped read not zero");
  chk_read_route: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && (i_addr == tof_cfg_pkg::OFS_ROUTE)) |=> (o_rdata == $past(route_q)))
    else $error("routing word read wrong");
  chk_pin1_route: assert property (@(posedge i_clk) disable iff (i_srst)
    i_pin1_from_sel1 |=> (o_general_pin_1 == $past(routed_event_1)))
    else $error("pin 1 routing wrong");
  chk_pin2_route: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_pin2_from_sel1 |=> (o_general_pin_2 == $past(routed_event_0)))
    else $error("pin 2 routing wrong");
  chk_pin3_route: assert property (@(posedge i_clk) disable iff (i_srst)
    i_pin3_route_en |=> (o_general_pin_3 == $past(routed_event_2) && o_general_pin_3_oe))
    else $error("pin 3 routing wrong");
  chk_pin3_second: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_pin3_route_en |=> (o_general_pin_3 == $past(i_sec_data_out)) &&
    (o_general_pin_3_oe == $past(i_sec_data_oe)))
    else $error("pin 3 secondary path wrong");
endmodule
`default_nettype wire

// ### testbench/host_bus_model.sv
// Purpose: host side of the register word port
// Assumes: requests launch on the falling edge and are taken on the rising edge
// Notes: released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  input wire logic i_clk,
  input wire logic [23:0] i_rdata,
  input wire logic i_rvalid,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [23:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 24'h000000;
  end

  // reserved fields go out as zero unless raw is set
  function automatic logic [23:0] legal(input logic [7:0] a, input logic [23:0] d);
    case (a)
      8'h0B: legal = d & 24'hFFFCFF;
      8'h0D: legal = d & 24'h81FF80;
      8'h0F: legal = d & 24'hFF7FFF;
      default: legal = d;
    endcase
  endfunction

  // a one in bit 16 of the frequency word starts calibration
  task automatic write_word(input logic [7:0] a, input logic [23:0] d, input logic raw);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = raw ? d : legal(a, d);
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  task automatic read_word(input logic [7:0] a, output logic [23:0] d);
    d = 24'hXXXXXX;
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~o_addr;
    for (int n = 0; n < 3; n++) begin
      if (i_rvalid === 1'b1) begin
        d = i_rdata;
        break;
      end
      @(negedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: the host model owns the register port; the bench drives events and pins
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_top;
  logic i_clk, i_srst, wr, rd, p2_in, p3_in, p1_s1, p2_s1, r3_en, sd_out, sd_oe, sw, vld;
  logic rvalid, pin1, pin1_oe, pin2, pin2_oe, pin3, pin3_oe, p2_sync, sd_in, ovl, start;
  logic fix_en, blk_en, meas;
  logic [7:0] addr, c_pwl, c_q, c_i;
  logic [23:0] wdata, rdata, got, frame_bits;
  logic [5:0] ev;
  logic [9:0] amb;
  logic [11:0] amb_bits;
  logic [3:0] temp_bits, div, cd;
  logic [14:0] ref_lim;
  int mismatches = 0;
  int checks_done = 0;
  int pulses = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'h9, 4'hA, 4'h2, 4'hF};
  logic [7:0] ofs [5] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
  logic [23:0] rst_v [5] = '{24'h0FC009, 24'h000000, 24'h006000, 24'h000000, 24'h144C4B};
  logic [23:0] ones_v [5] = '{24'hFFFCFF, 24'hFFFFFF, 24'h81FF80, 24'h000000, 24'hFF7FFF};
  // point, limit, result, expected overload
  logic [30:0] ov [4] = '{{10'h010, 10'h0C0, 10'h0D0, 1'b0}, {10'h010, 10'h0C0, 10'h0D1, 1'b1},
                          {10'h200, 10'h000, 10'h100, 1'b0}, {10'h000, 10'h3FE, 10'h3FF, 1'b1}};

  host_bus_model host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  tof_config_mux_ambient_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(addr), .i_wr(wr),
    .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_frame_sync_pulse(ev[0]), .i_subframe_sync_pulse(ev[1]), .i_seq_interrupt(ev[2]),
    .i_threshold_compare(ev[3]), .i_result_available(ev[4]), .i_frame_tally_lsb(ev[5]),
    .i_ambient_conversion_result(amb), .i_general_pin_2_in(p2_in), .i_general_pin_3_in(p3_in),
    .i_pin1_from_sel1(p1_s1), .i_pin2_from_sel1(p2_s1), .i_pin3_route_en(r3_en),
    .i_sec_data_out(sd_out), .i_sec_data_oe(sd_oe), .o_general_pin_1(pin1),
    .o_general_pin_1_oe(pin1_oe), .o_general_pin_2(pin2), .o_general_pin_2_oe(pin2_oe),
    .o_general_pin_3(pin3), .o_general_pin_3_oe(pin3_oe), .o_general_pin_2_sync(p2_sync),
    .o_sec_data_in(sd_in), .o_ambient_overload_indicator(ovl), .o_frame_result_bits(frame_bits),
    .o_ambient_result_bits(amb_bits), .o_ambient_phase_segment_coef(c_pwl),
    .o_ambient_quad_leak_coef(c_q), .o_ambient_inphase_leak_coef(c_i),
    .o_temp_read_bits(temp_bits), .o_freq_cal_start(start), .o_phase_freq_fix_enable(fix_en),
    .o_freq_cal_block_enable(blk_en), .o_measured_freq_use(meas), .o_cal_clock_divider(div),
    .o_ref_count_limit(ref_lim));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (start === 1'b1) pulses++;
  end

  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    i_srst = 1'b1;
    {p2_in, p3_in, p1_s1, p2_s1, r3_en, sd_out, sd_oe} = 7'h00;
    ev = 6'h10;
    amb = 10'h000;
    repeat (6) @(negedge i_clk);
    i_srst = 1'b0;
    // ----------------------------------------------------------------
    // reset values, unmapped place, selector 0 default route
    // ----------------------------------------------------------------
    for (int k = 0; k < 5; k++) begin
      host.read_word(ofs[k], got);
      `CHK("reset word", rst_v[k], got)
    end
    `CHK("pin1 reset route", 1'b1, pin1)
    `CHK("pin oe", 2'h3, {pin1_oe, pin2_oe})
    // ----------------------------------------------------------------
    // all ones written raw: reserved bits read zero, start pulses once
    // ----------------------------------------------------------------
    for (int k = 0; k < 5; k++) host.write_word(ofs[k], 24'hFFFFFF, 1'b1);
    for (int k = 0; k < 5; k++) begin
      host.read_word(ofs[k], got);
      `CHK("ones word", ones_v[k], got)
    end
    `CHK("start pulses", 1, pulses)
    `CHK("fix enable on", 1'b1, fix_en)
    `CHK("freq fields", {1'b1, 1'b1, 4'hF, 15'h7FFF}, {blk_en, meas, div, ref_lim})
    host.write_word(8'h0F, 24'h000000, 1'b0);
    repeat (3) @(negedge i_clk);
    `CHK("fix enable off", 1'b0, fix_en)
    `CHK("no start", 1, pulses)
    host.write_word(8'h0C, 24'hA53C81, 1'b0);
    `CHK("segment coef", 8'hA5, c_pwl)
    `CHK("quad coef", 8'h3C, c_q)
    `CHK("inphase coef", 8'h81, c_i)
    // ----------------------------------------------------------------
    // event routing over every valid code, invalid codes 2 and F last
    // ----------------------------------------------------------------
    r3_en = 1'b1;
    for (int k = 0; k < 8; k++) begin
      sw = k[0];
      cd = codes[k];
      vld = (k < 6);
      host.write_word(8'h0B, {10'h03F, cd, 2'h0, sw ? cd : 4'h2, sw ? 4'h2 : cd}, 1'b0);
      p1_s1 = sw;
      p2_s1 = !sw;
      ev = vld ? (6'h01 << k) : 6'h3F;
      repeat (3) @(negedge i_clk);
      `CHK("pin1 hit", vld, pin1)
      `CHK("pin2 other", 1'b0, pin2)
      `CHK("pin3 hit", {vld, 1'b1}, {pin3, pin3_oe})
      p2_s1 = sw;
      @(negedge i_clk);
      `CHK("pin2 hit", vld, pin2)
      ev = ~ev;
      repeat (3) @(negedge i_clk);
      `CHK("pins miss", 3'h0, {pin1, pin2, pin3})
    end
    r3_en = 1'b0;
    {sd_out, sd_oe, p2_in, p3_in} = 4'hF;
    repeat (3) @(negedge i_clk);
    `CHK("pin3 secondary", 2'h3, {pin3, pin3_oe})
    `CHK("pin inputs", 2'h3, {p2_sync, sd_in})
    sd_oe = 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK("pin3 released", 1'b0, pin3_oe)
    // ----------------------------------------------------------------
    // ambient overload at the limit, above it and below the point
    // ----------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      host.write_word(8'h0B, {ov[k][30:21], 14'h0009}, 1'b0);
      host.write_word(8'h0D, {k[0], 6'h00, ov[k][20:11], 7'h00}, 1'b0);
      amb = ov[k][10:1];
      repeat (3) @(negedge i_clk);
      `CHK("overload", ov[k][0], ovl)
      `CHK("frame bits", {1'b0, ov[k][0], 22'h000000}, frame_bits)
      `CHK("ambient bits", {ov[k][10:1], 2'h0}, amb_bits)
      `CHK("temp width", k[0] ? 4'hC : 4'h8, temp_bits)
      host.read_word(8'h0B, got);
      `CHK("calib point", ov[k][30:21], got[23:14])
    end
    print_verdict();
  end
endmodule
`default_nettype wire
